// [core/ppp_pkg.sv]
// Package: constants for the PROM programming port host controller
package ppp_pkg;
    localparam int PPP_AW = 17;
    localparam int PPP_DW = 8;
    localparam logic [16:0] PPP_ADDR_END = 17'h0EFFF;
    localparam int PPP_PAGE_BYTES = 4;
    localparam int PPP_MAX_TRIES = 10;
    localparam logic [7:0] PPP_ERASED = 8'hFF;
    localparam int PPP_CLK_NS = 50;
    localparam int PPP_PULSE_NS = 100000;
    localparam int PPP_PULSE_CYC = PPP_PULSE_NS / PPP_CLK_NS;
    localparam int PPP_SETUP_NS = 200;
    localparam int PPP_SETUP_CYC = (PPP_SETUP_NS + PPP_CLK_NS - 1) / PPP_CLK_NS;
    localparam int PPP_ACC_NS = 400;
    localparam int PPP_ACC_CYC = (PPP_ACC_NS + PPP_CLK_NS - 1) / PPP_CLK_NS;
    localparam logic [3:0] PPP_TRIES_W = 4'hA;
    typedef enum logic [1:0] {PPP_OP_READ, PPP_OP_BYTE, PPP_OP_PAGE} ppp_op_e;
endpackage

// [core/ppp_timer.sv]
// Cycle down-counter used for pulse, setup and access times
`timescale 1ns/1ps
module ppp_timer
    import ppp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Control
    input wire logic load,
    input wire logic [12:0] count,
    // Status
    output logic done
);
    typedef struct packed {
        logic [12:0] cnt;
    } ppp_tmr_s;
    ppp_tmr_s st_r;
    ppp_tmr_s st_nxt;
    always_comb begin
        st_nxt = st_r;
        if (load) begin
            st_nxt.cnt = count;
        end else if (st_r.cnt != 13'h0000) begin
            st_nxt.cnt = st_r.cnt - 13'h0001;
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    // From the count alone: load comes back from the sequencer's own decode
    assign done = (st_r.cnt == 13'h0000);
endmodule // ppp_timer

// [core/ppp_host.sv]
// Host controller that drives the PROM programming port pins
`timescale 1ns/1ps
module ppp_host
    import ppp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // User request
    input wire logic req,
    input wire ppp_op_e op,
    input wire logic [16:0] req_addr,
    input wire logic [31:0] req_data,
    output logic busy,
    output logic done,
    output logic fail,
    output logic [7:0] rd_data,
    output logic erased,
    // Device pins
    output logic reset_n_pin,
    output logic vpp_high,
    output logic chip_enable_n,
    output logic read_strobe_n,
    output logic program_pulse_n,
    output logic [16:0] address_lines,
    input wire logic [7:0] data_lines_in,
    output logic [7:0] data_lines_out,
    output logic data_lines_oe
);
    typedef enum logic [3:0] {
        PPP_IDLE, PPP_LATCH, PPP_LATCH_GAP, PPP_PULSE, PPP_PGAP,
        PPP_VERIFY, PPP_RD_SET, PPP_RD_ACC, PPP_DONE
    } ppp_state_e;
    typedef struct packed {
        ppp_state_e state;
        ppp_op_e op;
        logic [16:0] addr;
        logic [31:0] wdata;
        logic [1:0] idx;
        logic [3:0] tries;
        logic bad;
        logic busy;
        logic done;
        logic fail;
        logic erased;
        logic [7:0] rd_data;
        logic reset_n;
        logic vpp_high;
        logic ce_n;
        logic oe_n;
        logic pgm_n;
        logic [7:0] dout;
        logic doe;
    } ppp_host_s;
    ppp_host_s st_r;
    ppp_host_s st_nxt;
    logic tmr_load;
    logic [12:0] tmr_count;
    logic tmr_done;
    logic [7:0] exp_byte;
    // ****************************************
    // Timer
    // ****************************************
    ppp_timer u_timer (
        .clk(clk),
        .nrst(nrst),
        .load(tmr_load),
        .count(tmr_count),
        .done(tmr_done)
    );
    always_comb begin
        exp_byte = st_r.wdata[8 * st_r.idx +: 8];
    end
    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        tmr_load = 1'b0;
        tmr_count = 13'(PPP_SETUP_CYC);
        st_nxt.done = 1'b0;
        case (st_r.state)
            PPP_IDLE: begin
                // Idle pins: standby, data floating
                st_nxt.ce_n = 1'b1;
                st_nxt.oe_n = 1'b1;
                st_nxt.pgm_n = 1'b1;
                st_nxt.doe = 1'b0;
                st_nxt.busy = 1'b0;
                if (req) begin
                    st_nxt.busy = 1'b1;
                    st_nxt.op = op;
                    st_nxt.wdata = req_data;
                    st_nxt.tries = 4'h0;
                    st_nxt.fail = 1'b0;
                    st_nxt.reset_n = 1'b0;
                    st_nxt.idx = 2'h0;
                    tmr_load = 1'b1;
                    if (op == PPP_OP_READ) begin
                        st_nxt.vpp_high = 1'b0;
                        st_nxt.addr = req_addr;
                        st_nxt.state = PPP_RD_SET;
                    end else if (req_addr > PPP_ADDR_END) begin
                        st_nxt.fail = 1'b1;
                        st_nxt.state = PPP_DONE;
                    end else begin
                        st_nxt.vpp_high = 1'b1;
                        st_nxt.addr = (op == PPP_OP_PAGE) ? {req_addr[16:2], 2'b00}
                                                          : req_addr;
                        st_nxt.state = (op == PPP_OP_PAGE) ? PPP_LATCH : PPP_PGAP;
                    end
                end
            end
            PPP_LATCH: begin
                // CE high, OE low, PROGRAM_PULSE_N high latches a byte
                st_nxt.ce_n = 1'b1;
                st_nxt.oe_n = 1'b0;
                st_nxt.pgm_n = 1'b1;
                st_nxt.dout = exp_byte;
                st_nxt.doe = 1'b1;
                if (tmr_done) begin
                    st_nxt.oe_n = 1'b1;
                    tmr_load = 1'b1;
                    st_nxt.state = PPP_LATCH_GAP;
                end
            end
            PPP_LATCH_GAP: begin
                if (tmr_done) begin
                    tmr_load = 1'b1;
                    if (st_r.idx == 2'h3) begin
                        st_nxt.idx = 2'h0;
                        st_nxt.addr = {st_r.addr[16:2], 2'b00};
                        st_nxt.doe = 1'b0;
                        st_nxt.state = PPP_PGAP;
                    end else begin
                        st_nxt.idx = st_r.idx + 2'h1;
                        st_nxt.addr = {st_r.addr[16:2], st_r.idx + 2'h1};
                        st_nxt.state = PPP_LATCH;
                    end
                end
            end
            PPP_PGAP: begin
                // Setup before pulse; page floats data, byte drives it
                st_nxt.oe_n = 1'b1;
                st_nxt.ce_n = (st_r.op == PPP_OP_PAGE);
                st_nxt.dout = exp_byte;
                st_nxt.doe = (st_r.op == PPP_OP_BYTE);
                if (tmr_done) begin
                    st_nxt.pgm_n = 1'b0;
                    st_nxt.tries = st_r.tries + 4'h1;
                    tmr_load = 1'b1;
                    tmr_count = 13'(PPP_PULSE_CYC);
                    st_nxt.state = PPP_PULSE;
                end
            end
            PPP_PULSE: begin
                // Pins frozen for the whole pulse
                if (tmr_done) begin
                    st_nxt.pgm_n = 1'b1;
                    st_nxt.doe = 1'b0;
                    st_nxt.idx = 2'h0;
                    tmr_load = 1'b1;
                    tmr_count = 13'(PPP_ACC_CYC);
                    st_nxt.bad = 1'b0;
                    st_nxt.state = PPP_VERIFY;
                end
            end
            PPP_VERIFY: begin
                st_nxt.ce_n = 1'b0;
                st_nxt.oe_n = 1'b0;
                if (tmr_done && !st_r.oe_n) begin
                    tmr_load = 1'b1;
                    tmr_count = 13'(PPP_ACC_CYC);
                    st_nxt.bad = st_r.bad | (data_lines_in != exp_byte);
                    if (st_r.op == PPP_OP_PAGE && st_r.idx != 2'h3) begin
                        st_nxt.idx = st_r.idx + 2'h1;
                        st_nxt.addr = {st_r.addr[16:2], st_r.idx + 2'h1};
                    end else begin
                        st_nxt.oe_n = 1'b1;
                        st_nxt.idx = 2'h0;
                        st_nxt.addr = (st_r.op == PPP_OP_PAGE) ? {st_r.addr[16:2], 2'b00}
                                                               : st_r.addr;
                        if (!(st_r.bad | (data_lines_in != exp_byte))) begin
                            st_nxt.state = PPP_DONE;
                        end else if (st_r.tries >= PPP_TRIES_W) begin
                            st_nxt.fail = 1'b1;
                            st_nxt.state = PPP_DONE;
                        end else begin
                            st_nxt.state = PPP_PGAP;
                        end
                    end
                end
            end
            PPP_RD_SET: begin
                // Address settles before the strobes drop
                if (tmr_done) begin
                    st_nxt.ce_n = 1'b0;
                    st_nxt.oe_n = 1'b0;
                    tmr_load = 1'b1;
                    tmr_count = 13'(PPP_ACC_CYC);
                    st_nxt.state = PPP_RD_ACC;
                end
            end
            PPP_RD_ACC: begin
                if (tmr_done) begin
                    st_nxt.rd_data = data_lines_in;
                    st_nxt.erased = (data_lines_in == PPP_ERASED);
                    st_nxt.oe_n = 1'b1;
                    st_nxt.state = PPP_DONE;
                end
            end
            PPP_DONE: begin
                st_nxt.ce_n = 1'b1;
                st_nxt.oe_n = 1'b1;
                st_nxt.pgm_n = 1'b1;
                st_nxt.doe = 1'b0;
                st_nxt.done = 1'b1;
                st_nxt.busy = 1'b0;
                st_nxt.state = PPP_IDLE;
            end
            default: begin
                st_nxt.state = PPP_IDLE;
            end
        endcase
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
            st_r.state <= PPP_IDLE;
            st_r.reset_n <= 1'b1;
            st_r.ce_n <= 1'b1;
            st_r.oe_n <= 1'b1;
            st_r.pgm_n <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign busy = st_r.busy;
    assign done = st_r.done;
    assign fail = st_r.fail;
    assign rd_data = st_r.rd_data;
    assign erased = st_r.erased;
    assign reset_n_pin = st_r.reset_n;
    assign vpp_high = st_r.vpp_high;
    assign chip_enable_n = st_r.ce_n;
    assign read_strobe_n = st_r.oe_n;
    assign program_pulse_n = st_r.pgm_n;
    assign address_lines = st_r.addr;
    assign data_lines_out = st_r.dout;
    assign data_lines_oe = st_r.doe;
    // ****************************************
    // Checks
    // ****************************************
    logic [12:0] pw_cnt;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pw_cnt <= 13'h0000;
        end else begin
            pw_cnt <= program_pulse_n ? 13'h0000 : pw_cnt + 13'h0001;
        end
    end
    AST_PULSE_WIDTH: assert property (@(posedge clk) disable iff (!nrst)
        $rose(program_pulse_n) |-> $past(pw_cnt) >= 13'(PPP_PULSE_CYC - 1))
        else $error("program pulse too short");
    AST_PULSE_RESET: assert property (@(posedge clk) disable iff (!nrst)
        !program_pulse_n |-> !reset_n_pin && vpp_high)
        else $error("pulse outside programming mode");
    AST_PAGE_FLOAT: assert property (@(posedge clk) disable iff (!nrst)
        (!program_pulse_n && chip_enable_n) |-> !data_lines_oe && read_strobe_n)
        else $error("page pulse with data driven");
    AST_BYTE_DRIVE: assert property (@(posedge clk) disable iff (!nrst)
        (!program_pulse_n && !chip_enable_n) |-> data_lines_oe && read_strobe_n)
        else $error("byte pulse without data");
    AST_STABLE: assert property (@(posedge clk) disable iff (!nrst)
        (!program_pulse_n && $past(!program_pulse_n)) |->
        $stable(address_lines) && $stable(data_lines_out) && $stable(chip_enable_n))
        else $error("pins moved during pulse");
    AST_NO_CONTEND: assert property (@(posedge clk) disable iff (!nrst)
        (!read_strobe_n && !chip_enable_n) |-> !data_lines_oe)
        else $error("host drives during device output");
    AST_VERIFY_AFTER: assert property (@(posedge clk) disable iff (!nrst)
        $rose(program_pulse_n) |-> ##[1:12] (!chip_enable_n && !read_strobe_n))
        else $error("no verify after pulse");
    AST_RANGE: assert property (@(posedge clk) disable iff (!nrst)
        !program_pulse_n |-> address_lines <= PPP_ADDR_END)
        else $error("write above array top");
    AST_TRIES: assert property (@(posedge clk) disable iff (!nrst)
        st_r.tries <= PPP_TRIES_W)
        else $error("too many attempts");
    COV_READ: cover property (@(posedge clk) disable iff (!nrst)
        done && !vpp_high && !fail);
    COV_PAGE: cover property (@(posedge clk) disable iff (!nrst)
        done && st_r.op == PPP_OP_PAGE && !fail);
    COV_BYTE_RETRY: cover property (@(posedge clk) disable iff (!nrst)
        done && st_r.op == PPP_OP_BYTE && st_r.tries > 4'h1);
endmodule // ppp_host

// [test/ppp_dev_model.sv]
// Behavioural model of the programmable memory behind the programming port
`timescale 1ns/1ps
module ppp_dev_model
    import ppp_pkg::*;
(
    // Mode pins
    input wire logic reset_n_pin,
    input wire logic vpp_high,
    input wire logic chip_enable_n,
    input wire logic read_strobe_n,
    input wire logic program_pulse_n,
    input wire logic [16:0] address_lines,
    // Data bus
    input wire logic [7:0] bus_in,
    input wire logic host_oe,
    output logic [7:0] dev_data,
    output logic dev_oe,
    // Fault control and status
    input wire logic stuck,
    output int pulses,
    output logic viol
);
    logic [7:0] mem [0:131071];
    logic [7:0] latch_q [0:3];
    logic [14:0] page_q;
    logic [16:0] a_q;
    logic [7:0] d_q;
    logic [2:0] m_q;
    time t_q;
    wire in_mode = !reset_n_pin;
    // ****
    // Output drive
    // ****
    // Floats unless enabled, read strobe low and pulse high
    assign dev_oe = in_mode && !chip_enable_n && !read_strobe_n
        && program_pulse_n;
    assign dev_data = mem[address_lines];
    initial begin
        foreach (mem[i]) mem[i] = PPP_ERASED;
        pulses = 0;
        viol = 1'b0;
    end
    always @(posedge dev_oe or posedge host_oe) begin
        #1;
        if (dev_oe && host_oe) viol = 1'b1;
    end
    // ****
    // Page latch and programming
    // ****
    always @(address_lines or bus_in or host_oe or chip_enable_n or read_strobe_n
        or program_pulse_n) begin
        if (in_mode && vpp_high && chip_enable_n && !read_strobe_n && program_pulse_n
            && host_oe) begin
            latch_q[address_lines[1:0]] = bus_in;
            page_q = address_lines[16:2];
        end
    end
    always @(negedge program_pulse_n) begin
        t_q = $time;
        a_q = address_lines;
        d_q = bus_in;
        m_q = {vpp_high, chip_enable_n, read_strobe_n};
        #1;
        if (in_mode && chip_enable_n && read_strobe_n && host_oe) viol = 1'b1;
    end
    // Read strobe low with pulse low is inhibit: no write
    always @(posedge program_pulse_n) begin
        if (in_mode && read_strobe_n) begin
            pulses = pulses + 1;
            if ($time - t_q < PPP_PULSE_NS || a_q !== address_lines || !vpp_high
                || m_q !== {vpp_high, chip_enable_n, read_strobe_n}) begin
                viol = 1'b1;
            end else if (stuck) begin
                viol = viol;
            end else if (!chip_enable_n) begin
                mem[a_q] = mem[a_q] & d_q;
            end else begin
                for (int i = 0; i < 4; i++) begin
                    mem[{page_q, i[1:0]}] &= latch_q[i];
                end
            end
        end
    end
endmodule // ppp_dev_model

// [test/tb_prom_program_port.sv]
// Self-checking testbench for the programming port host controller
`timescale 1ns/1ps
module tb_prom_program_port;
    import ppp_pkg::*;
    logic clk, nrst, req, busy, done, fail, erased, reset_n_pin, vpp_high, stuck, viol;
    logic chip_enable_n, read_strobe_n, program_pulse_n, data_lines_oe, dev_oe;
    ppp_op_e op;
    logic [16:0] req_addr, address_lines;
    logic [31:0] req_data;
    logic [7:0] rd_data, data_lines_in, data_lines_out, dev_data, last_bus;
    int pulses, n_errors, tests_run, p0;

    ppp_host dut (.clk(clk), .nrst(nrst), .req(req), .op(op), .req_addr(req_addr),
        .req_data(req_data), .busy(busy), .done(done), .fail(fail), .rd_data(rd_data),
        .erased(erased), .reset_n_pin(reset_n_pin), .vpp_high(vpp_high),
        .chip_enable_n(chip_enable_n), .read_strobe_n(read_strobe_n),
        .program_pulse_n(program_pulse_n), .address_lines(address_lines),
        .data_lines_in(data_lines_in), .data_lines_out(data_lines_out),
        .data_lines_oe(data_lines_oe));
    ppp_dev_model dev (.reset_n_pin(reset_n_pin), .vpp_high(vpp_high),
        .chip_enable_n(chip_enable_n), .read_strobe_n(read_strobe_n),
        .program_pulse_n(program_pulse_n), .address_lines(address_lines),
        .bus_in(data_lines_in), .host_oe(data_lines_oe), .dev_data(dev_data),
        .dev_oe(dev_oe), .stuck(stuck), .pulses(pulses), .viol(viol));
    // Undriven bus shows the inverse of its last value, never a lucky match
    assign data_lines_in = data_lines_oe ? data_lines_out : (dev_oe ? dev_data : ~last_bus);
    always @(posedge clk) if (data_lines_oe || dev_oe) last_bus <= data_lines_in;
    initial clk = 1'b0;
    always #25 clk = ~clk;
    // ****
    // Shared tasks
    // ****
    task automatic test_done;
        $display("Counts: %0d compares, %0d mismatches", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask
    task automatic run_op(input ppp_op_e o, input logic [16:0] a, input logic [31:0] d);
        int n;
        @(negedge clk);
        req = 1'b1;
        op = o;
        req_addr = a;
        req_data = d;
        @(negedge clk);
        req = 1'b0;
        chk(busy, 1'b1, "busy after request");
        chk(reset_n_pin, 1'b0, "device held in reset");
        n = 0;
        while (done !== 1'b1 && n < 30000) begin
            @(negedge clk);
            n++;
        end
        chk(done, 1'b1, "done seen");
        chk(busy, 1'b0, "busy at done");
        chk(data_lines_oe, 1'b0, "bus released");
    endtask
    task automatic rd(input logic [16:0] a, input logic [7:0] exp);
        run_op(PPP_OP_READ, a, 32'h0);
        chk(rd_data, exp, "read data");
        chk(erased, exp == PPP_ERASED, "erased flag");
        chk(fail, 1'b0, "read fail");
        chk(vpp_high, 1'b0, "read supply level");
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_byte;
        p0 = pulses;
        rd(17'h00123, 8'hFF);
        run_op(PPP_OP_BYTE, 17'h00123, 32'hFFFFFF5A);
        chk(fail, 1'b0, "byte fail");
        chk(vpp_high, 1'b1, "write supply level");
        chk(pulses, p0 + 1, "byte pulses");
        rd(17'h00123, 8'h5A);
        $display("test byte done");
    endtask
    task automatic t_page;
        p0 = pulses;
        run_op(PPP_OP_PAGE, 17'h0EFFE, 32'hC3A51E87);
        chk(fail, 1'b0, "page fail");
        chk(pulses, p0 + 1, "page pulses");
        for (int i = 0; i < 4; i++) begin
            rd(17'h0EFFC + 17'(i), 8'(32'hC3A51E87 >> (8 * i)));
        end
        rd(17'h0EFFB, 8'hFF);
        $display("test page done");
    endtask
    task automatic t_refused;
        p0 = pulses;
        run_op(PPP_OP_BYTE, 17'h0F000, 32'h00000011);
        chk(fail, 1'b1, "byte over top");
        run_op(PPP_OP_PAGE, 17'h0F004, 32'h0);
        chk(fail, 1'b1, "page over top");
        chk(pulses, p0, "no pulse");
        rd(17'h0F000, 8'hFF);
        $display("test refused done");
    endtask
    task automatic t_retry;
        p0 = pulses;
        stuck = 1'b1;
        run_op(PPP_OP_BYTE, 17'h00200, 32'h0);
        chk(fail, 1'b1, "retry fail");
        chk(pulses, p0 + PPP_MAX_TRIES, "retry pulses");
        stuck = 1'b0;
        rd(17'h00200, 8'hFF);
        $display("test retry done");
    endtask
    initial begin
        repeat (80000) @(posedge clk);
        n_errors++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        test_done();
    end
    initial begin
        nrst = 1'b0;
        req = 1'b0;
        op = PPP_OP_READ;
        req_addr = 17'h00000;
        req_data = 32'h0;
        stuck = 1'b0;
        last_bus = 8'h00;
        n_errors = 0;
        tests_run = 0;
        repeat (16) @(negedge clk);
        chk({reset_n_pin, chip_enable_n, read_strobe_n, program_pulse_n, data_lines_oe},
            5'h1E, "reset pins");
        nrst = 1'b1;
        t_byte();
        t_page();
        t_refused();
        t_retry();
        chk(viol, 1'b0, "pin protocol");
        test_done();
    end
endmodule // tb_prom_program_port
